/* File: core_seq_model.sv */
// model of the core sequencer, interrupt logic and program memory
`timescale 1ns/10ps
`default_nettype none
module core_seq_model
    import return_address_stack_pkg::*;
(
    // command from the bench
    input wire logic op_valid,
    input wire core_op_type op,
    input wire logic [20:0] op_target,
    input wire logic sw_busy,
    // to and from the stack
    input wire logic [20:0] pc_q,
    output logic irq_ack_hi,
    output logic irq_ack_lo,
    output logic call_req,
    output logic [20:0] call_target,
    output logic ret_req,
    output logic push_req,
    output logic pop_req,
    output logic jump_req,
    output logic [20:0] jump_target,
    output logic step_req,
    output logic [15:0] fetch_data
);
    // interrupts held off while software owns the top entry
    assign irq_ack_hi = op_valid && op == op_irq_hi && !sw_busy;
    assign irq_ack_lo = op_valid && op == op_irq_lo && !sw_busy;
    assign call_req = op_valid && op == op_call;
    assign ret_req = op_valid && op == op_ret;
    assign push_req = op_valid && op == op_push;
    assign pop_req = op_valid && op == op_pop;
    assign jump_req = op_valid && op == op_jump;
    assign step_req = op_valid && op == op_step;
    assign call_target = op_target;
    assign jump_target = op_target;
    // memory answers everywhere; the stack must blank what is unbuilt
    assign fetch_data = {1'b1, pc_q[15:1]};
endmodule : core_seq_model
`default_nettype wire

/* File: return_address_stack.sv */
// return address stack with program counter and apb register slave
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "return_address_stack_consts.svh"
module return_address_stack
    import return_address_stack_pkg::*;
#(
    parameter int DEPTH = 31,
    parameter int PTR_W = 5,
    parameter int PC_W = 21,
    parameter bit LARGE_VARIANT = 1'b1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sequencer and interrupt logic
    input wire logic irq_ack_hi,
    input wire logic irq_ack_lo,
    input wire logic call_req,
    input wire logic [PC_W-1:0] call_target,
    input wire logic ret_req,
    input wire logic push_req,
    input wire logic pop_req,
    input wire logic jump_req,
    input wire logic [PC_W-1:0] jump_target,
    input wire logic step_req,
    // program memory fetch
    input wire logic [15:0] fetch_data,
    output logic [PC_W-1:0] pc_q,
    output logic [15:0] fetch_word_q,
    output logic overflow_reset_q
);

    // ------------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------------
    // slot zero has no storage behind it
    logic [PC_W-1:0] ram [1:DEPTH];
    logic [PTR_W-1:0] ptr_q;
    logic [PTR_W-1:0] ptr_d;
    logic full_q;
    logic full_d;
    logic unf_q;
    logic unf_d;
    logic ovf_en_q;
    logic [PC_W-1:0] pc_d;
    logic ovf_fire;
    logic ram_we;
    logic [PTR_W-1:0] ram_idx;
    logic [PC_W-1:0] ram_wdata;
    logic [PC_W-1:0] top_entry;
    core_op_type op;
    apb_state_type apb_q;
    logic commit_wr;
    logic [31:0] rd_word;
    logic rd_ok;

    localparam logic [21:0] PROG_BYTES =
        LARGE_VARIANT ? `RAS_BYTES_LARGE : `RAS_BYTES_SMALL;
    localparam logic [PTR_W-1:0] TOP = PTR_W'(DEPTH);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [PC_W-1:0] slot_value(
        input logic [PTR_W-1:0] idx
    );
        logic [PC_W-1:0] v;
        v = '0;
        if (idx != '0) begin
            v = ram[idx];
        end
        return v;
    endfunction : slot_value

    function automatic logic in_prog(input logic [PC_W-1:0] addr);
        return {1'b0, addr} < PROG_BYTES;
    endfunction : in_prog

    always_comb top_entry = slot_value(ptr_q);

    // ------------------------------------------------------------------
    // core operation decode
    // ------------------------------------------------------------------
    // one operation per cycle; interrupt acknowledge outranks the rest
    always_comb begin
        if (irq_ack_hi) begin
            op = op_irq_hi;
        end else if (irq_ack_lo) begin
            op = op_irq_lo;
        end else if (call_req) begin
            op = op_call;
        end else if (ret_req) begin
            op = op_ret;
        end else if (push_req) begin
            op = op_push;
        end else if (pop_req) begin
            op = op_pop;
        end else if (jump_req) begin
            op = op_jump;
        end else if (step_req) begin
            op = op_step;
        end else begin
            op = op_none;
        end
    end

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    // one wait state: pready rises in the second access cycle
    assign commit_wr = psel && penable && pready && pwrite;

    always_comb begin
        rd_word = '0;
        rd_ok = 1'b1;
        case (paddr)
            `RAS_OFF_PTR: begin
                rd_word[`RAS_BIT_FULL] = full_q;
                rd_word[`RAS_BIT_UNF] = unf_q;
                rd_word[PTR_W-1:0] = ptr_q;
            end
            `RAS_OFF_TOP_ENTRY_UPPER_BYTE: begin
                rd_word[4:0] = top_entry[20:16];
            end
            `RAS_OFF_TOP_ENTRY_HIGH_BYTE: begin
                rd_word[7:0] = top_entry[15:8];
            end
            `RAS_OFF_TOP_ENTRY_LOW_BYTE: begin
                rd_word[7:0] = top_entry[7:0];
            end
            `RAS_OFF_CFG: begin
                rd_word[`RAS_BIT_OVF_EN] = ovf_en_q;
            end
            `RAS_OFF_PC: begin
                rd_word[PC_W-1:0] = pc_q;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_q <= apb_idle;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            case (apb_q)
                apb_idle: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    if (psel && penable) begin
                        apb_q <= apb_answer;
                        pready <= 1'b1;
                        pslverr <= !rd_ok;
                        prdata <= pwrite ? 32'h00000000 : rd_word;
                    end
                end
                apb_answer: begin
                    apb_q <= apb_idle;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    apb_q <= apb_idle;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_en_q <= `RAS_CFG_OVF_RESET;
        end else if (commit_wr && paddr == `RAS_OFF_CFG) begin
            ovf_en_q <= pwdata[`RAS_BIT_OVF_EN];
        end
    end

    // ------------------------------------------------------------------
    // stack pointer, flags and storage writes
    // ------------------------------------------------------------------
    // a core operation wins over a software write in the same cycle;
    // software is expected to mask interrupts around such accesses
    always_comb begin
        ptr_d = ptr_q;
        full_d = full_q;
        unf_d = unf_q;
        ram_we = 1'b0;
        ram_idx = ptr_q;
        ram_wdata = pc_q;
        ovf_fire = 1'b0;
        // software side: clear-only flags, pointer takes effect at once
        if (commit_wr && paddr == `RAS_OFF_PTR) begin
            ptr_d = pwdata[PTR_W-1:0];
            if (!pwdata[`RAS_BIT_FULL]) begin
                full_d = 1'b0;
            end
            if (!pwdata[`RAS_BIT_UNF]) begin
                unf_d = 1'b0;
            end
        end
        if (commit_wr && ptr_q != '0) begin
            ram_idx = ptr_q;
            ram_wdata = top_entry;
            case (paddr)
                `RAS_OFF_TOP_ENTRY_UPPER_BYTE: begin
                    ram_we = 1'b1;
                    ram_wdata[20:16] = pwdata[4:0];
                end
                `RAS_OFF_TOP_ENTRY_HIGH_BYTE: begin
                    ram_we = 1'b1;
                    ram_wdata[15:8] = pwdata[7:0];
                end
                `RAS_OFF_TOP_ENTRY_LOW_BYTE: begin
                    ram_we = 1'b1;
                    ram_wdata[7:0] = pwdata[7:0];
                end
                default: begin
                    ram_we = 1'b0;
                end
            endcase
        end
        // core side
        case (op)
            op_irq_hi, op_irq_lo, op_call, op_push: begin
                ptr_d = ptr_q;
                ram_we = 1'b0;
                if (ptr_q != TOP) begin
                    // increment first, then write the new slot
                    ptr_d = PTR_W'(ptr_q + 1'b1);
                    ram_idx = ptr_d;
                    ram_we = 1'b1;
                    ram_wdata = pc_q;
                    if (ptr_d == TOP) begin
                        full_d = 1'b1;
                        if (ovf_en_q) begin
                            ram_wdata = PC_W'(pc_q + `RAS_PC_STEP);
                            ptr_d = `RAS_PTR_RESET;
                            ovf_fire = 1'b1;
                        end
                    end
                end else begin
                    // saturated: entry 31 is kept, pointer stays
                    full_d = 1'b1;
                end
            end
            op_ret, op_pop: begin
                ptr_d = ptr_q;
                ram_we = 1'b0;
                if (ptr_q == '0) begin
                    unf_d = 1'b1;
                end else begin
                    ptr_d = PTR_W'(ptr_q - 1'b1);
                end
            end
            default: begin
                ram_idx = ram_idx;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q <= `RAS_PTR_RESET;
            full_q <= 1'b0;
            unf_q <= 1'b0;
        end else begin
            ptr_q <= ptr_d;
            full_q <= full_d;
            unf_q <= unf_d;
        end
    end

    // storage has no reset; slot zero never holds data
    always_ff @(posedge pclk) begin
        if (ram_we && ram_idx != '0) begin
            ram[ram_idx] <= ram_wdata;
        end
    end

    // ------------------------------------------------------------------
    // program counter and fetch
    // ------------------------------------------------------------------
    // pc_q already points past the current instruction when pushed;
    // the pc latches live elsewhere and are never touched here
    always_comb begin
        pc_d = pc_q;
        case (op)
            op_irq_hi: pc_d = `RAS_VEC_HI;
            op_irq_lo: pc_d = `RAS_VEC_LO;
            op_call: pc_d = call_target;
            op_ret: pc_d = top_entry;
            op_jump: pc_d = jump_target;
            op_step: pc_d = PC_W'(pc_q + `RAS_PC_STEP);
            default: pc_d = pc_q;
        endcase
        if (ovf_fire) begin
            pc_d = `RAS_PC_RESET;
        end
        pc_d[0] = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= `RAS_PC_RESET;
            overflow_reset_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            overflow_reset_q <= ovf_fire;
        end
    end

    // unimplemented space reads as a nop; underflow vector is no reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_word_q <= 16'h0000;
        end else begin
            fetch_word_q <= in_prog(pc_q) ? fetch_data : 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    logic is_push;
    assign is_push = (op == op_call) || (op == op_push)
        || (op == op_irq_hi) || (op == op_irq_lo);

    chk_push_bumps_ptr: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_push && ptr_q < PTR_W'(DEPTH - 1)
        |=> ptr_q == PTR_W'($past(ptr_q) + 1'b1))
        else $error("push did not advance the pointer by one");

    chk_push_stores_pc: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_push && ptr_q < PTR_W'(DEPTH - 1)
        |=> top_entry == $past(pc_q))
        else $error("pushed slot does not hold the pc");

    chk_ret_loads_top: assert property (
        @(posedge pclk) disable iff (!presetn)
        op == op_ret && ptr_q != '0
        |=> pc_q == {$past(top_entry[PC_W-1:1]), 1'b0}
            && ptr_q == PTR_W'($past(ptr_q) - 1'b1))
        else $error("return did not load top entry and drop pointer");

    chk_underflow_sets: assert property (
        @(posedge pclk) disable iff (!presetn)
        op == op_ret && ptr_q == '0
        |=> pc_q == `RAS_PC_RESET && unf_q && ptr_q == '0)
        else $error("empty return did not underflow to zero");

    chk_full_saturates: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_push && ptr_q == TOP && !ovf_en_q
        |=> ptr_q == TOP && full_q && $stable(top_entry))
        else $error("saturated push moved pointer or overwrote entry");

    chk_overflow_resets: assert property (
        @(posedge pclk) disable iff (!presetn)
        is_push && ptr_q == PTR_W'(DEPTH - 1) && ovf_en_q
        |=> ptr_q == '0 && full_q && overflow_reset_q
            && pc_q == `RAS_PC_RESET)
        else $error("overflow push did not reset with full set");

    chk_irq_vectors: assert property (
        @(posedge pclk) disable iff (!presetn)
        irq_ack_hi |=> pc_q == `RAS_VEC_HI || overflow_reset_q)
        else $error("interrupt did not vector to 0008h");

    chk_fetch_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        !in_prog(pc_q) |=> fetch_word_q == 16'h0000)
        else $error("fetch outside memory did not read zero");

    chk_pop_keeps_pc: assert property (
        @(posedge pclk) disable iff (!presetn)
        op == op_pop && ptr_q != '0
        |=> pc_q == $past(pc_q) && ptr_q == PTR_W'($past(ptr_q) - 1'b1))
        else $error("pop instruction changed pc or missed decrement");

    chk_flags_unsettable: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit_wr && op == op_none && !full_q && !unf_q
        |=> !full_q && !unf_q)
        else $error("software write set a stack flag");

endmodule : return_address_stack
`default_nettype wire

/* File: return_address_stack_consts.svh */
// constants for the return address stack block
//
// Overview of operation
// - pc is 21 bits over 2 Mbytes; fetch beyond memory returns zero (nop).
// - program memory is 4 Kbytes small variant, 8 Kbytes large variant.
// - execution starts at 0000h; interrupts vector to 0008h and 0018h.
// - calls and interrupt acknowledge push the pc; up to 31 nested entries.
// - return, return with literal and return from interrupt pop into pc.
// - calls and returns leave the pc upper and high latches untouched.
// - 31 words of 21 bits, 5-bit pointer reset to zero; slot zero empty.
// - push increments the pointer first, then writes pc to the new slot.
// - pop loads pc from the current slot, then decrements the pointer.
// - stack lies outside program and data space; reached via its registers.
// - upper, high and low top entry registers read and write current slot.
// - pointer ranges 0 to 31 and software can read and write it.
// - full flag sets after 31 unpopped pushes; cleared by software or reset.
// - with overflow reset, 31st push stores pc+2, sets full, resets core.
// - without overflow reset, pointer saturates at 31 and entry 31 is kept.
// - pop on empty loads zero to pc, sets underflow, pointer stays zero.
// - underflow vectoring to zero is no reset; registers keep their values.
// - register holds full bit 7, underflow bit 6, bit 5 zero, pointer 4-0.
// - software may read and clear the flags but never set them.
// - push instruction bumps pointer and stores pc; software may then edit.
// - pop instruction only decrements the pointer; pc does not change.
`ifndef RETURN_ADDRESS_STACK_CONSTS_SVH
`define RETURN_ADDRESS_STACK_CONSTS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RAS_OFF_PTR 8'h00
`define RAS_OFF_TOP_ENTRY_UPPER_BYTE 8'h04
`define RAS_OFF_TOP_ENTRY_HIGH_BYTE 8'h08
`define RAS_OFF_TOP_ENTRY_LOW_BYTE 8'h0C
`define RAS_OFF_CFG 8'h10
`define RAS_OFF_PC 8'h14

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define RAS_BIT_FULL 7
`define RAS_BIT_UNF 6
`define RAS_BIT_OVF_EN 0
`define RAS_PTR_RESET 5'h00
`define RAS_CFG_OVF_RESET 1'b1

// ----------------------------------------------------------------------
// program space
// ----------------------------------------------------------------------
`define RAS_PC_RESET 21'h000000
`define RAS_VEC_HI 21'h000008
`define RAS_VEC_LO 21'h000018
`define RAS_PC_STEP 21'h000002
`define RAS_BYTES_SMALL 22'h001000
`define RAS_BYTES_LARGE 22'h002000

`endif

/* File: return_address_stack_pkg.sv */
// types shared by the return address stack block
`default_nettype none
package return_address_stack_pkg;
    typedef enum logic [3:0] {
        op_none, op_irq_hi, op_irq_lo, op_call, op_ret,
        op_push, op_pop, op_jump, op_step
    } core_op_type;
    typedef enum logic [0:0] {apb_idle, apb_answer} apb_state_type;
endpackage : return_address_stack_pkg
`default_nettype wire

/* File: tb_return_address_stack.sv */
// self-checking bench for the return address stack
`timescale 1ns/10ps
`default_nettype none
`include "return_address_stack_consts.svh"
module tb_return_address_stack
    import return_address_stack_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, seed;
    logic op_valid, irq_ack_hi, irq_ack_lo, call_req, ret_req, push_req;
    logic pop_req, jump_req, step_req, overflow_reset_q;
    core_op_type op;
    logic [20:0] op_target, call_target, jump_target, pc_q, pc_m, t;
    logic [15:0] fetch_data, fetch_word_q;
    logic [32:0] exp_q[$];
    logic [20:0] stk_m [0:31];
    logic full_m, unf_m, ovf_en_m;
    int err_total, compares, ovf_seen, ovf_exp, ptr_m;

    return_address_stack DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_ack_hi,
        .irq_ack_lo, .call_req, .call_target, .ret_req, .push_req,
        .pop_req, .jump_req, .jump_target, .step_req, .fetch_data,
        .pc_q, .fetch_word_q, .overflow_reset_q);
    core_seq_model seq (.op_valid, .op, .op_target, .sw_busy(psel), .pc_q,
        .irq_ack_hi, .irq_ack_lo, .call_req, .call_target, .ret_req,
        .push_req, .pop_req, .jump_req, .jump_target, .step_req,
        .fetch_data);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic check(string name, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask : check

    task automatic results();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // read data of a refused access is not defined, only the error
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            logic [32:0] e;
            e = exp_q.pop_front();
            check("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
            if (!e[32]) begin
                check("prdata", e[31:0], prdata);
            end
        end
    end

    always @(posedge pclk) begin
        if (overflow_reset_q) begin
            ovf_seen++;
        end
    end

    task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
            logic [32:0] e);
        exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(logic [7:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd

    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d, {1'b0, 32'h0});
    endtask : wr

    task automatic wr_ptr(logic [7:0] v);
        wr(`RAS_OFF_PTR, {24'h0, v});
        ptr_m = v[4:0];
        full_m = full_m & v[7];
        unf_m = unf_m & v[6];
    endtask : wr_ptr

    task automatic check_state();
        logic [20:0] s;
        s = (ptr_m == 0) ? 21'h0 : stk_m[ptr_m];
        rd(`RAS_OFF_PTR, {24'h0, full_m, unf_m, 1'b0, ptr_m[4:0]});
        rd(`RAS_OFF_PC, {11'h0, pc_m});
        rd(`RAS_OFF_TOP_ENTRY_UPPER_BYTE, {27'h0, s[20:16]});
        rd(`RAS_OFF_TOP_ENTRY_HIGH_BYTE, {24'h0, s[15:8]});
        rd(`RAS_OFF_TOP_ENTRY_LOW_BYTE, {24'h0, s[7:0]});
    endtask : check_state

    function automatic logic [20:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[20:0] & 21'h1FFFFE;
    endfunction : rnd

    // expected stack behaviour, then one op pulse to the sequencer
    task automatic core(core_op_type k, logic [20:0] tg);
        logic psh;
        logic ovf;
        psh = k inside {op_irq_hi, op_irq_lo, op_call, op_push};
        ovf = psh && ptr_m == 30 && ovf_en_m;
        if (ovf) begin
            stk_m[31] = pc_m + 21'h2;
            full_m = 1'b1;
            ptr_m = 0;
            pc_m = 21'h0;
            ovf_exp++;
        end else if (psh && ptr_m == 31) begin
            full_m = 1'b1;
        end else if (psh) begin
            ptr_m++;
            stk_m[ptr_m] = pc_m;
            full_m = full_m | (ptr_m == 31);
        end
        if (!ovf) begin
            case (k)
                op_irq_hi: pc_m = `RAS_VEC_HI;
                op_irq_lo: pc_m = `RAS_VEC_LO;
                op_call, op_jump: pc_m = tg;
                op_step: pc_m = pc_m + 21'h2;
                op_ret, op_pop: begin
                    if (ptr_m == 0) begin
                        unf_m = 1'b1;
                        pc_m = (k == op_ret) ? 21'h0 : pc_m;
                    end else begin
                        pc_m = (k == op_ret) ? stk_m[ptr_m] : pc_m;
                        ptr_m--;
                    end
                end
                default: ;
            endcase
        end
        op_valid <= 1'b1;
        op <= k;
        op_target <= tg;
        @(posedge pclk);
        op_valid <= 1'b0;
        @(posedge pclk);
        check_state();
    endtask : core

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        op_valid = 1'b0;
        op = op_none;
        op_target = 21'h0;
        seed = 32'hE09D58B9;
        {err_total, compares, ovf_seen, ovf_exp, ptr_m} = '0;
        {full_m, unf_m, pc_m} = '0;
        ovf_en_m = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        check_state();
        rd(`RAS_OFF_CFG, 32'h1);
        apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
        wr(`RAS_OFF_PC, 32'h0000_1234);
        wr_ptr(8'hC0);
        check_state();
        // nesting of calls, interrupts and an explicit push
        core(op_jump, 21'h000100);
        for (int i = 0; i < 3; i++) core(op_call, rnd());
        core(op_irq_hi, 21'h0);
        core(op_irq_lo, 21'h0);
        core(op_push, 21'h0);
        t = rnd();
        wr(`RAS_OFF_TOP_ENTRY_UPPER_BYTE, {27'h0, t[20:16]});
        wr(`RAS_OFF_TOP_ENTRY_HIGH_BYTE, {24'h0, t[15:8]});
        wr(`RAS_OFF_TOP_ENTRY_LOW_BYTE, {24'h0, t[7:0]});
        stk_m[ptr_m] = t;
        for (int i = 0; i < 3; i++) core(op_ret, 21'h0);
        core(op_pop, 21'h0);
        wr_ptr(8'h05);
        core(op_ret, 21'h0);
        for (int i = 0; i < 5; i++) core(op_pop, 21'h0);
        core(op_ret, 21'h0);
        rd(`RAS_OFF_CFG, 32'h1);
        wr_ptr(8'h00);
        // saturation without reset, then overflow with reset
        wr(`RAS_OFF_CFG, 32'h0);
        ovf_en_m = 1'b0;
        for (int i = 0; i < 30; i++) core(op_call, rnd());
        core(op_step, 21'h0);
        core(op_push, 21'h0);
        core(op_step, 21'h0);
        core(op_push, 21'h0);
        wr_ptr(8'h1F);
        wr(`RAS_OFF_CFG, 32'h1);
        ovf_en_m = 1'b1;
        wr_ptr(8'h1E);
        core(op_call, rnd());
        wr_ptr(8'h9F);
        check_state();
        // fetch at the last built word and just beyond it
        core(op_jump, 21'h001FFE);
        check("fetch_word", 32'h8FFF, {16'h0, fetch_word_q});
        core(op_jump, 21'h002000);
        check("fetch_word", 32'h0, {16'h0, fetch_word_q});
        check("overflow_resets", ovf_exp, ovf_seen);
        check("pending_notes", 32'h0, exp_q.size());
        results();
    end

    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        results();
    end
endmodule : tb_return_address_stack
`default_nettype wire
